/* hw/host_bus_reset_clock_port.sv */
/*
  host side port: multiplexed 8-bit register bus, interrupt pin, reset and clock outputs.
  assumes every pin input is asynchronous to mclk and evt comes from mclk logic.
*/
// Behaviour
// - strobe mode write; no select means idle
// - read drives addressed byte in either mode
// - split-command write stores bus byte
// - select tied high still decodes by commands
// - strobe mode uses select as data strobe
// - pending enabled events pull interrupt low
// - interrupt register access releases interrupt line
// - internal reset is pin or soft bit
// - hold reset eight clocks for oscillator
// - release internal reset on a clock edge
// - clock output is uninverted oscillator copy outside internal reset
// - timeslot rate is clock over ratio times 16
// - codes 0-7 select ratios 1 to 128
// - codes 8-15 select ratios 1.5 to 192
// - address latched on falling address strobe
// - clearing one of several gives release pulse
`timescale 1ns/1ns
module host_bus_reset_clock_port #(
  parameter int EVENTS = 6
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        ad_in,
  output logic      [7:0]        ad_out,
  output logic                   ad_oe_n,
  input  wire logic              ale,
  input  wire logic              rd_cmd,
  input  wire logic              wr_cmd,
  input  wire logic              cs,
  output logic                   int_out,
  output logic                   int_oe_n,
  input  wire logic              reset_pin,
  input  wire logic              osc_in,
  output logic                   osc_out,
  output logic                   clock_buffer_out,
  output logic                   timeslot_clock,
  input  wire logic [EVENTS-1:0] evt
);
  initial
  begin
    if (EVENTS < 1 || EVENTS > 8)
      $error("EVENTS must be 1 to 8");
  end

  ctl_if ctl ();

  reset_gen u_reset_gen (
    .mclk      (mclk),
    .rst       (rst),
    .reset_pin (reset_pin),
    .ctl       (ctl.rst_gen)
  );

  slot_divider u_slot_divider (
    .mclk (mclk),
    .rst  (rst),
    .ctl  (ctl.div)
  );

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [7:0] ad_s1_reg;
  logic [7:0] ad_s2_reg;
  logic [3:0] pins_s1_reg;
  logic [3:0] pins_s2_reg;
  logic       osc_s1_reg;
  logic       osc_s2_reg;
  logic       ale_d_reg;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ad_s1_reg   <= 8'h00;
      ad_s2_reg   <= 8'h00;
      pins_s1_reg <= 4'h0;
      pins_s2_reg <= 4'h0;
      osc_s1_reg  <= 1'b0;
      osc_s2_reg  <= 1'b0;
      ale_d_reg   <= 1'b0;
    end
    else
    begin
      ad_s1_reg   <= ad_in;
      ad_s2_reg   <= ad_s1_reg;
      pins_s1_reg <= {ale, rd_cmd, wr_cmd, cs};
      pins_s2_reg <= pins_s1_reg;
      osc_s1_reg  <= osc_in;
      osc_s2_reg  <= osc_s1_reg;
      ale_d_reg   <= pins_s2_reg[3];
    end

  // ************************************************
  // access decode
  // ************************************************
  logic                     ale_s;
  logic                     rd_s;
  logic                     wr_s;
  logic                     cs_s;
  logic                     ale_fall;
  logic                     acc_rd;
  logic                     acc_wr;
  host_port_pkg::acc_e      state_reg;
  host_port_pkg::acc_e      state_next;
  logic                     wr_stb;
  logic                     int_range;
  logic                     int_access;

  assign ale_s    = pins_s2_reg[3];
  assign rd_s     = pins_s2_reg[2];
  assign wr_s     = pins_s2_reg[1];
  assign cs_s     = pins_s2_reg[0];
  assign ale_fall = ale_d_reg && !ale_s;
  // the host keeps select low across a mode change, so decode needs no mode flag
  assign acc_rd   = cs_s && !rd_s && wr_s;
  assign acc_wr   = cs_s && !wr_s;

  assign state_next = acc_rd ? host_port_pkg::ACC_READ :
                      acc_wr ? host_port_pkg::ACC_WRITE : host_port_pkg::ACC_IDLE;
  // commit at the trailing edge, when the data has stood for the whole strobe
  assign wr_stb     = (state_reg == host_port_pkg::ACC_WRITE) && (state_next != host_port_pkg::ACC_WRITE);

  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;

  assign int_range  = (addr_reg >= host_port_pkg::OFF_INT_FIRST) && (addr_reg <= host_port_pkg::OFF_INT_LAST);
  assign int_access = (state_reg != host_port_pkg::ACC_IDLE) && int_range;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      state_reg <= host_port_pkg::ACC_IDLE;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= ale_fall ? ad_s2_reg : addr_reg;
      wdata_reg <= acc_wr ? ad_s2_reg : wdata_reg;
    end

  // ************************************************
  // registers
  // ************************************************
  logic [3:0]        div_reg;
  logic [7:0]        cmd_reg;
  logic [EVENTS-1:0] int_en_reg;
  logic [EVENTS-1:0] int_stat_reg;
  logic [EVENTS-1:0] stat_clear;
  logic [7:0]        rdata;
  logic              pending;

  assign stat_clear = (wr_stb && addr_reg == host_port_pkg::OFF_INT_STATUS) ? wdata_reg[EVENTS-1:0] : '0;
  assign pending    = |(int_stat_reg & int_en_reg);

  assign rdata = (addr_reg == host_port_pkg::OFF_DIVIDER)    ? {4'h0, div_reg} :
                 (addr_reg == host_port_pkg::OFF_COMMAND)    ? cmd_reg :
                 (addr_reg == host_port_pkg::OFF_INT_ENABLE) ? 8'(int_en_reg) :
                 (addr_reg == host_port_pkg::OFF_INT_STATUS) ? 8'(int_stat_reg) : 8'h00;

  assign ctl.soft_reset = cmd_reg[host_port_pkg::SOFT_RESET_POS];
  assign ctl.div_code   = div_reg;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      div_reg      <= host_port_pkg::DIVIDER_RESET;
      cmd_reg      <= host_port_pkg::COMMAND_RESET;
      int_en_reg   <= '0;
    end
    else if (ctl.int_rst)
    begin
      div_reg      <= host_port_pkg::DIVIDER_RESET;
      cmd_reg      <= host_port_pkg::COMMAND_RESET;
      int_en_reg   <= '0;
    end
    else
    begin
      if (wr_stb && addr_reg == host_port_pkg::OFF_DIVIDER)
        div_reg <= wdata_reg[3:0];
      if (wr_stb && addr_reg == host_port_pkg::OFF_COMMAND)
        cmd_reg <= wdata_reg;
      if (wr_stb && addr_reg == host_port_pkg::OFF_INT_ENABLE)
        int_en_reg <= wdata_reg[EVENTS-1:0];
    end

  // ************************************************
  // status bits
  // ************************************************
  // a new event in the clearing cycle survives
  for (genvar i = 0; i < EVENTS; i++)
  begin : g_stat
    always_ff @(posedge mclk or posedge rst)
      if (rst)
        int_stat_reg[i] <= 1'b0;
      else if (ctl.int_rst)
        int_stat_reg[i] <= 1'b0;
      else
        int_stat_reg[i] <= (int_stat_reg[i] && !stat_clear[i]) || evt[i];
  end

  // ************************************************
  // interrupt line
  // ************************************************
  logic [1:0] rel_reg;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      rel_reg  <= 2'h0;
      int_oe_n <= 1'b1;
    end
    else
    begin
      rel_reg  <= int_access ? 2'(host_port_pkg::STROBE_CYCLES) : (rel_reg != 2'h0 ? rel_reg - 2'h1 : 2'h0);
      int_oe_n <= !(pending && rel_reg == 2'h0 && !int_access) || ctl.int_rst;
    end

  assign int_out = 1'b0;

  // ************************************************
  // bus drive and clock outputs
  // ************************************************
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ad_out           <= 8'h00;
      ad_oe_n          <= 1'b1;
      osc_out          <= 1'b0;
      clock_buffer_out <= 1'b0;
      timeslot_clock   <= 1'b0;
    end
    else
    begin
      ad_out           <= rdata;
      ad_oe_n          <= !acc_rd;
      osc_out          <= ctl.osc_run && !osc_s2_reg;
      clock_buffer_out <= osc_s2_reg && !ctl.int_rst;
      timeslot_clock   <= ctl.ts_tick;
    end

  // ************************************************
  // checks
  // ************************************************
  a_read_drive: assert property (@(posedge mclk) disable iff (rst) acc_rd |=> !ad_oe_n && ad_out == $past(rdata))
    else $error("read access did not drive the bus");
  a_bus_float: assert property (@(posedge mclk) disable iff (rst) !acc_rd |=> ad_oe_n)
    else $error("bus driven outside a read");
  a_no_access: assert property (@(posedge mclk) disable iff (rst)
    (!cs_s || (rd_s && wr_s)) |=> state_reg == host_port_pkg::ACC_IDLE)
    else $error("access decoded while idle");
  a_divider_write: assert property (@(posedge mclk) disable iff (rst || ctl.int_rst)
    wr_stb && addr_reg == host_port_pkg::OFF_DIVIDER |=> div_reg == $past(wdata_reg[3:0]))
    else $error("divider write lost");
  a_strobe_write: assert property (@(posedge mclk) disable iff (rst)
    cs_s && !rd_s && !wr_s ##1 !cs_s |-> state_reg == host_port_pkg::ACC_WRITE && wr_stb)
    else $error("strobe mode write not committed");
  a_split_write: assert property (@(posedge mclk) disable iff (rst)
    cs_s && rd_s && !wr_s ##1 cs_s && rd_s && wr_s |-> wr_stb)
    else $error("split mode write not committed");
  a_addr_latch: assert property (@(posedge mclk) disable iff (rst) ale_fall |=> addr_reg == $past(ad_s2_reg))
    else $error("address not latched on strobe fall");
  a_int_release: assert property (@(posedge mclk) disable iff (rst) int_access |=> int_oe_n)
    else $error("interrupt held during interrupt register access");
  a_int_pulse: assert property (@(posedge mclk) disable iff (rst) $fell(int_access) |=> int_oe_n[*3])
    else $error("interrupt release pulse too short");
  a_int_assert: assert property (@(posedge mclk) disable iff (rst || ctl.int_rst)
    pending && rel_reg == 2'h0 && !int_access |=> !int_oe_n)
    else $error("pending interrupt not signalled");
  a_status_set: assert property (@(posedge mclk) disable iff (rst || ctl.int_rst)
    |evt |=> (int_stat_reg & $past(evt)) == $past(evt))
    else $error("event lost from status");
  a_soft_reset: assert property (@(posedge mclk) disable iff (rst)
    cmd_reg[host_port_pkg::SOFT_RESET_POS] |=> ##1 ctl.int_rst)
    else $error("soft reset bit ignored");
  a_reset_clear: assert property (@(posedge mclk) disable iff (rst)
    ctl.int_rst |=> div_reg == host_port_pkg::DIVIDER_RESET && cmd_reg == host_port_pkg::COMMAND_RESET)
    else $error("registers not cleared by internal reset");
  a_osc_enable: assert property (@(posedge mclk) disable iff (rst)
    ctl.int_rst |=> osc_out == !$past(osc_s2_reg))
    else $error("oscillator not enabled during reset");
  a_clock_copy: assert property (@(posedge mclk) disable iff (rst)
    !ctl.int_rst |=> clock_buffer_out == $past(osc_s2_reg))
    else $error("clock output does not follow the oscillator");
  a_tick_out: assert property (@(posedge mclk) disable iff (rst)
    ctl.ts_tick |=> timeslot_clock)
    else $error("timeslot tick not passed to the output");
endmodule

/* hw/reset_gen.sv */
/*
  internal reset: filtered pin reset or'd with the software bit, held for the oscillator wait.
  assumes reset_pin is asynchronous to mclk and soft_reset comes from mclk logic.
*/
`timescale 1ns/1ns
module reset_gen (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic reset_pin,
  ctl_if.rst_gen    ctl
);
  logic       pin_s1_reg;
  logic       pin_s2_reg;
  logic [1:0] filt_reg;
  logic [3:0] wait_reg;
  logic       rst_req;
  logic       pin_ok;

  // ************************************************
  // filter and hold
  // ************************************************
  // pulses shorter than the filter never reach the chip
  assign pin_ok  = pin_s2_reg && (filt_reg == 2'(host_port_pkg::FILTER_CYCLES - 1));
  assign rst_req = pin_ok || ctl.soft_reset;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      filt_reg   <= 2'h0;
    end
    else
    begin
      pin_s1_reg <= reset_pin;
      pin_s2_reg <= pin_s1_reg;
      filt_reg   <= !pin_s2_reg ? 2'h0 : (pin_ok ? filt_reg : filt_reg + 2'h1);
    end

  // release only on a clock edge, so a dead clock keeps the chip in reset
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wait_reg    <= 4'(host_port_pkg::OSC_WAIT_CYCLES);
      ctl.int_rst <= 1'b1;
      ctl.osc_run <= 1'b1;
    end
    else
    begin
      wait_reg    <= rst_req ? 4'(host_port_pkg::OSC_WAIT_CYCLES) :
                     (wait_reg != 4'h0 ? wait_reg - 4'h1 : 4'h0);
      ctl.int_rst <= rst_req || (wait_reg != 4'h0);
      ctl.osc_run <= ctl.osc_run || ctl.int_rst;
    end

  a_osc_wait_hold: assert property (@(posedge mclk) disable iff (rst) rst_req |=> ctl.int_rst[*8])
    else $error("internal reset released before oscillator wait");
  a_sync_release: assert property (@(posedge mclk) disable iff (rst)
    $fell(ctl.int_rst) |-> $past(wait_reg, 2) == 4'h1 && !$past(rst_req))
    else $error("internal reset released early");
endmodule

/* hw/slot_divider.sv */
/*
  timeslot tick generator: one mclk pulse every ratio times sixteen clocks.
  assumes the divider code is stable between writes and mclk is the oscillator clock.
*/
`timescale 1ns/1ns
module slot_divider (
  input  wire logic mclk,
  input  wire logic rst,
  ctl_if.div        ctl
);
  // counting in half clocks keeps the 1.5 ratios exact
  localparam logic [13:0] BASE_INT  = 14'(host_port_pkg::SLOT_CLOCKS * 2);
  localparam logic [13:0] BASE_FRAC = 14'(host_port_pkg::SLOT_CLOCKS * 3);

  logic [13:0] period_half;
  logic [13:0] acc_reg;
  logic [13:0] acc_sum;
  logic        wrap;

  assign period_half = (ctl.div_code[3] ? BASE_FRAC : BASE_INT) << ctl.div_code[2:0];
  assign acc_sum     = acc_reg + 14'h2;
  assign wrap        = acc_sum >= period_half;

  // ************************************************
  // tick
  // ************************************************
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      acc_reg     <= 14'h0;
      ctl.ts_tick <= 1'b0;
    end
    else if (ctl.int_rst)
    begin
      acc_reg     <= 14'h0;
      ctl.ts_tick <= 1'b0;
    end
    else
    begin
      // restart at zero on a tick, so a smaller code never bunches ticks
      acc_reg     <= wrap ? 14'h0 : acc_sum;
      ctl.ts_tick <= wrap;
    end

  a_tick_spacing: assert property (@(posedge mclk) disable iff (rst || ctl.int_rst)
    ctl.ts_tick |=> !ctl.ts_tick[*8])
    else $error("timeslot ticks too close");
endmodule

/* inc/ctl_if.sv */
/*
  carrier between the port core, the reset generator and the timeslot divider.
  assumes all three sit on mclk.
*/
`timescale 1ns/1ns
interface ctl_if;
  logic       soft_reset;
  logic       int_rst;
  logic       osc_run;
  logic [3:0] div_code;
  logic       ts_tick;

  modport core    (output soft_reset, output div_code, input int_rst, input osc_run, input ts_tick);
  modport rst_gen (input soft_reset, output int_rst, output osc_run);
  modport div     (input div_code, input int_rst, output ts_tick);
endinterface

/* inc/host_port_pkg.sv */
/*
  constants, reset values and enumerations for the host bus, reset and clock port.
  assumes a single 125 MHz clock named mclk drives every user of these values.
*/
package host_port_pkg;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] OFF_DIVIDER     = 8'h00;
  localparam logic [7:0] OFF_COMMAND     = 8'h03;
  localparam logic [7:0] OFF_INT_FIRST   = 8'h08;
  localparam logic [7:0] OFF_INT_ENABLE  = 8'h09;
  localparam logic [7:0] OFF_INT_STATUS  = 8'h0a;
  localparam logic [7:0] OFF_INT_LAST    = 8'h0b;
  localparam int         SOFT_RESET_POS  = 7;
  localparam logic [7:0] COMMAND_RESET   = 8'h00;
  localparam logic [3:0] DIVIDER_RESET   = 4'h0;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int WR_STROBE_NS    = 20;
  localparam int STROBE_CYCLES   = (WR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_FILTER_NS   = 12;
  localparam int FILTER_CYCLES   = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_WAIT_CYCLES = 8;
  localparam int SLOT_CLOCKS     = 16;

  // ************************************************
  // bus access states
  // ************************************************
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b11
  } acc_e;
endpackage

/* testbench/host_cpu_model.sv */
/*
  processor model: drives the multiplexed bus in split-command or strobe mode.
  assumes the bench resolves the shared bus and calls its tasks from one process.
*/
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic       mclk,
  input  wire logic [7:0] ad_bus,
  output logic      [7:0] ad_drv,
  output logic            ad_en,
  output logic            ale,
  output logic            rd_cmd,
  output logic            wr_cmd,
  output logic            cs
);
  // ************************************************
  // bus cycles
  // ************************************************
  logic strobe_mode;
  logic cs_tied;

  initial
  begin
    {ad_drv, ad_en, ale, cs, strobe_mode, cs_tied} = '0;
    rd_cmd = 1'b1;
    wr_cmd = 1'b1;
  end

  // address and mode phases are four clocks: the port needs three for its synchronisers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_mode(input logic sm, input logic tied);
    cs = 1'b0;
    cyc(4);
    strobe_mode = sm;
    cs_tied     = tied & ~sm;
    rd_cmd      = ~sm;
    wr_cmd      = 1'b1;
    cyc(4);
    cs = cs_tied;
    cyc(4);
  endtask

  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    ad_drv = addr;
    ad_en  = 1'b1;
    ale    = 1'b1;
    cyc(4);
    ale = 1'b0;
    cyc(4);
    ad_drv = wdata;
    ad_en  = ~rd;
    if (strobe_mode)
    begin
      wr_cmd = rd;
      cyc(1);
      cs = 1'b1;
    end
    else
    begin
      rd_cmd = ~rd;
      wr_cmd = rd;
      cs     = 1'b1;
    end
    cyc(5);
    rdata = ad_bus;
    cs    = cs_tied;
    ad_en = 1'b0;
    if (!strobe_mode)
    begin
      rd_cmd = 1'b1;
      wr_cmd = 1'b1;
    end
    cyc(6);
  endtask
endmodule

/* testbench/tb_host_bus_reset_clock_port.sv */
/*
  testbench for the host bus, reset and clock port.
  assumes the package, carrier, design files and processor model are compiled first.
*/
`timescale 1ns/1ns
module tb_host_bus_reset_clock_port;
  // ************************************************
  // harness
  // ************************************************
  typedef struct packed {logic sm; logic rd; logic [7:0] addr; logic [7:0] data;} row_s;

  logic       mclk;
  logic       rst;
  logic       reset_pin;
  logic       osc_in;
  logic [5:0] evt;
  logic [7:0] ad_last   = '0;
  logic       saw_high  = 1'b0;
  logic [7:0] ad_bus, ad_drv, ad_out, rv;
  logic       ad_en, ale, rd_cmd, wr_cmd, cs, ad_oe_n;
  logic       int_out, int_oe_n, int_level, clock_buffer_out, timeslot_clock, osc_out;
  int         n_fail, cmp_count, n, m;
  row_s       rows [0:9] = '{'{0, 1, 8'h00, 8'h00}, '{1, 1, 8'h03, 8'h00}, '{0, 0, 8'h00, 8'h05},
                           '{1, 1, 8'h00, 8'h05}, '{1, 0, 8'h03, 8'h12}, '{0, 1, 8'h03, 8'h12},
                           '{0, 0, 8'h20, 8'ha5}, '{1, 1, 8'h20, 8'h00}, '{0, 1, 8'h08, 8'h00},
                           '{1, 1, 8'h0b, 8'h00}};

  // undriven bus has no pull: show a changing pattern, not the last value
  assign ad_bus    = !ad_oe_n ? ad_out : (ad_en ? ad_drv : ~ad_last);
  assign int_level = int_oe_n ? 1'b1 : int_out;

  always #4 mclk = ~mclk;

  always
  begin
    repeat (10) @(posedge mclk);
    #1 osc_in = ~osc_in;
  end

  always @(posedge mclk)
  begin
    ad_last <= ad_bus;
    if (int_level === 1'b1)
      saw_high <= 1'b1;
    if (ad_oe_n === 1'b0 && ad_en)
      chk("ad_oe_n while host drives", 16'h1, 16'(ad_oe_n));
  end

  host_bus_reset_clock_port #(.EVENTS(6)) uut (
    .mclk(mclk), .rst(rst), .ad_in(ad_bus), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale(ale),
    .rd_cmd(rd_cmd), .wr_cmd(wr_cmd), .cs(cs), .int_out(int_out), .int_oe_n(int_oe_n),
    .reset_pin(reset_pin), .osc_in(osc_in), .osc_out(osc_out), .clock_buffer_out(clock_buffer_out),
    .timeslot_clock(timeslot_clock), .evt(evt)
  );

  host_cpu_model cpu (
    .mclk(mclk), .ad_bus(ad_bus), .ad_drv(ad_drv), .ad_en(ad_en), .ale(ale),
    .rd_cmd(rd_cmd), .wr_cmd(wr_cmd), .cs(cs)
  );

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.access(1'b0, a, d, rv);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
    cpu.access(1'b1, a, 8'h00, rv);
    chk(name, 16'(e), 16'(rv));
  endtask

  // bounded so a dead divider ends as a mismatch, not a hang
  task automatic tick_wait(output int k);
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    while (timeslot_clock !== 1'b1 && k < 7000);
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  initial
  begin
    // all codes of the divider take at most about 41k clocks
    #(80000 * 8);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    mclk      = 1'b0;
    rst       = 1'b1;
    reset_pin = 1'b0;
    osc_in    = 1'b0;
    evt       = 6'h00;
    repeat (16) @(posedge mclk);
    #1;
    chk("ad_oe_n in reset", 16'h1, 16'(ad_oe_n));
    chk("int_oe_n in reset", 16'h1, 16'(int_oe_n));
    rst = 1'b0;
    cpu.cyc(5);
    chk("clock_buffer_out in hold", 16'h0, 16'(clock_buffer_out));
    cpu.cyc(12);
    for (int i = 0; i < 10; i++)
    begin
      cpu.set_mode(rows[i].sm, 1'b0);
      if (rows[i].rd)
        rd("table read", rows[i].addr, rows[i].data);
      else
        wr(rows[i].addr, rows[i].data);
    end
    cpu.set_mode(1'b0, 1'b1);
    wr(8'h03, 8'h5a);
    rd("tied select read", 8'h03, 8'h5a);
    cpu.set_mode(1'b0, 1'b0);
    evt = 6'h01;
    cpu.cyc(1);
    evt = 6'h00;
    cpu.cyc(6);
    chk("int masked", 16'h1, 16'(int_level));
    wr(8'h09, 8'h03);
    cpu.cyc(4);
    chk("int pending", 16'h0, 16'(int_level));
    evt = 6'h02;
    cpu.cyc(1);
    evt      = 6'h00;
    saw_high = 1'b0;
    rd("int status", 8'h0a, 8'h03);
    cpu.cyc(4);
    chk("int released on read", 16'h1, 16'(saw_high));
    chk("int back after read", 16'h0, 16'(int_level));
    saw_high = 1'b0;
    wr(8'h0a, 8'h01);
    cpu.cyc(4);
    chk("pulse on clear", 16'h1, 16'(saw_high));
    chk("int still pending", 16'h0, 16'(int_level));
    wr(8'h0a, 8'h02);
    cpu.cyc(4);
    chk("int cleared", 16'h1, 16'(int_level));
    evt = 6'h3c;
    cpu.cyc(1);
    evt = 6'h00;
    rd("status upper bits", 8'h0a, 8'h3c);
    cpu.cyc(4);
    chk("upper bits masked", 16'h1, 16'(int_level));
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h00, 8'(c));
      tick_wait(n);
      tick_wait(n);
      tick_wait(n);
      tick_wait(m);
      chk("two timeslots", 16'((c < 8 ? 2 << c : 3 << (c - 8)) * 16), 16'(n + m));
    end
    for (int k = 0; k < 4; k++)
    begin
      @(osc_in);
      cpu.cyc(7);
      chk("clock_buffer_out", 16'(osc_in), 16'(clock_buffer_out));
      chk("osc_out", 16'(!osc_in), 16'(osc_out));
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 8'h03);
      if (k == 0)
        wr(8'h03, 8'h80);
      else
      begin
        reset_pin = 1'b1;
        cpu.cyc(4);
        reset_pin = 1'b0;
      end
      cpu.cyc(30);
      rd("divider after reset", 8'h00, 8'h00);
      rd("command after reset", 8'h03, 8'h00);
    end
    wr(8'h00, 8'h07);
    reset_pin = 1'b1;
    cpu.cyc(1);
    reset_pin = 1'b0;
    cpu.cyc(20);
    rd("divider after glitch", 8'h00, 8'h07);
    chk("ad_oe_n idle", 16'h1, 16'(ad_oe_n));
    print_verdict();
  end
endmodule
